/* tb_top.sv */
// self-checking bench for the switch matrix host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, reset, sync_n;
    logic [7:0] h_data, d_out, s_out, s_oe, v;
    logic h_cd, h_wr_n, h_rd_n, h_cs1_n, h_cs2_n, d_oe, rdy_n, oe;
    logic [3:0] h_match;
    int bad_count, checked, low_n;
    tssm_host_model host (.i_clk(clk), .i_data(d_out), .i_data_oe(d_oe), .o_data(h_data),
        .o_cmd_data(h_cd), .o_wr_n(h_wr_n), .o_rd_n(h_rd_n), .o_cs_first_n(h_cs1_n),
        .o_cs_second_n(h_cs2_n), .o_match(h_match));
    tssm_switch dut (.i_clk(clk), .i_reset(reset), .i_sync_n(sync_n),
        .i_serial_in_buses(8'h96), .o_serial_out_buses(s_out), .o_serial_out_buses_oe(s_oe),
        .i_data(h_data), .o_data(d_out), .o_data_oe(d_oe), .i_cmd_data(h_cd),
        .i_wr_n(h_wr_n), .i_rd_n(h_rd_n), .i_chip_select_first_n(h_cs1_n),
        .i_chip_select_second_n(h_cs2_n), .i_match_a_first(h_match[3]),
        .i_match_b_first(h_match[2]), .i_match_a_second(h_match[1]),
        .i_match_b_second(h_match[0]), .o_data_ready_n(rdy_n));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // data bytes (two or four) then opcode, then room to execute
    task automatic send(input int n, input logic [7:0] a, b, c, d, input logic [4:0] op);
        if (n == 4) begin
            host.wr(1'b0, a);
            host.wr(1'b0, b);
        end
        host.wr(1'b0, c);
        host.wr(1'b0, d);
        host.wr(1'b1, {3'h0, op});
        low_n = 0;
        // count the cycles in which ready is low while the instruction runs
        repeat (10) begin
            @(negedge clk);
            if (!rdy_n) begin
                low_n++;
            end
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // reset with sync held low, idle levels checked, then init waited out
    task automatic t_reset();
        reset = 1'b1;
        sync_n = 1'b0;
        repeat (12) @(negedge clk);
        chk("data_oe_reset", 8'h00, {7'h0, d_oe});
        chk("pcm_oe_reset", 8'h00, s_oe);
        chk("pcm_out_reset", 8'hff, s_out);
        chk("ready_n_reset", 8'h01, {7'h0, rdy_n});
        reset = 1'b0;
        sync_n = 1'b1;
        // one whole frame of initialisation before any command
        repeat (600) @(negedge clk);
        $display("test reset done");
    endtask
    // input bus 0 slot 7 routed to output bus 1 slot 5, read back three ways
    task automatic t_connect();
        send(4, 8'h00, 8'h07, 8'h01, 8'h05, tssm_pkg::OP_CONNECT);
        send(2, 8'h00, 8'h00, 8'h01, 8'h05, tssm_pkg::OP_SAMPLE);
        host.rd(1'b0, v, oe);
        chk("speech_rb", 8'h00, v);
        send(2, 8'h00, 8'h00, 8'h01, 8'h05, tssm_pkg::OP_CTRL_WORD);
        chk("ready_pulse", 8'h02, 8'(low_n));
        host.rd(1'b0, v, oe);
        chk("ctrl_word_rb", 8'h07, v);
        host.rd(1'b1, v, oe);
        chk("ctrl_word_op", 8'h25, v);
        // mask picks buses 0 and 1; neither slot 0 byte carries the empty label
        send(2, 8'h00, 8'h00, 8'h00, 8'h03, tssm_pkg::OP_EXTRACT);
        repeat (520) @(negedge clk);
        host.rd(1'b1, v, oe);
        chk("msg_count", 8'h02, v);
        $display("test connect and extract done");
    endtask
    // a reset in mid-run must wipe the route made above
    task automatic t_reset_clears();
        t_reset();
        send(2, 8'h00, 8'h00, 8'h01, 8'h05, tssm_pkg::OP_SAMPLE);
        host.rd(1'b0, v, oe);
        chk("store_reset", 8'hff, v);
        $display("test mid-run reset done");
    endtask
    task automatic t_invalid();
        host.wr(1'b1, 8'h1f);
        repeat (4) @(negedge clk);
        chk("ready_n_invalid", 8'h00, {7'h0, rdy_n});
        send(2, 8'h00, 8'h00, 8'h01, 8'h00, tssm_pkg::OP_DISCONNECT);
        chk("ready_n_valid", 8'h01, {7'h0, rdy_n});
        $display("test invalid opcode done");
    endtask
    task automatic t_load_sample();
        send(4, 8'h0a, 8'h05, 8'h00, 8'h03, tssm_pkg::OP_LOAD_BYTE);
        send(2, 8'h00, 8'h00, 8'h00, 8'h03, tssm_pkg::OP_SAMPLE);
        host.rd(1'b0, v, oe);
        chk("first_rb", 8'ha5, v);
        chk("oe_match", 8'h01, {7'h0, oe});
        host.rd(1'b1, v, oe);
        chk("second_rb", {3'h0, tssm_pkg::OP_SAMPLE}, v);
        host.set_match(4'h8);
        host.rd(1'b0, v, oe);
        chk("oe_mismatch", 8'h00, {7'h0, oe});
        // unmatched load byte must act as a disconnection
        send(4, 8'h03, 8'h0c, 8'h00, 8'h03, tssm_pkg::OP_LOAD_BYTE);
        host.set_match(4'h0);
        send(2, 8'h00, 8'h00, 8'h00, 8'h03, tssm_pkg::OP_SAMPLE);
        host.rd(1'b0, v, oe);
        chk("unmatched_load", 8'hff, v);
        $display("test load and sample done");
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        bad_count = 0;
        checked = 0;
        t_reset();
        t_invalid();
        t_load_sample();
        t_connect();
        t_reset_clears();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire

/* tssm_host_model.sv */
// host processor model driving the switch host port
`timescale 1ns/1ps
`default_nettype none
module tssm_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_data,
    input wire logic i_data_oe,
    output logic [7:0] o_data,
    output logic o_cmd_data,
    output logic o_wr_n,
    output logic o_rd_n,
    output logic o_cs_first_n,
    output logic o_cs_second_n,
    output logic [3:0] o_match
);
    // both selects held low, one could be tied
    initial begin
        o_data = 8'h00;
        o_cmd_data = 1'b0;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_cs_first_n = 1'b0;
        o_cs_second_n = 1'b0;
        o_match = 4'h0;
    end
    // sets the match pins {a1,b1,a2,b2}
    task automatic set_match(input logic [3:0] m);
        @(negedge i_clk);
        o_match = m;
    endtask
    // strobe moves after a clock fall
    task automatic wr(input logic c, input logic [7:0] d);
        @(negedge i_clk);
        o_cmd_data = c;
        o_data = d;
        o_wr_n = 1'b0;
        @(negedge i_clk);
        o_wr_n = 1'b1;
        @(negedge i_clk);
        // released bus shows a changed value, not the old byte
        o_data = ~d;
    endtask
    // read strobe, value taken just before release
    task automatic rd(input logic c, output logic [7:0] v, output logic oe);
        @(negedge i_clk);
        o_cmd_data = c;
        o_rd_n = 1'b0;
        @(negedge i_clk);
        @(negedge i_clk);
        v = i_data;
        oe = i_data_oe;
        o_rd_n = 1'b1;
    endtask
endmodule
`default_nettype wire

/* tssm_pkg.sv */
// constants shared by the time-slot switch matrix
`default_nettype none
package tssm_pkg;
    // ----------------------------------------
    // frame structure
    // ----------------------------------------
    localparam int BUSES = 8;
    localparam int SLOTS = 32;
    localparam int ENTRIES = 256;
    localparam int CNT_W = 9; // counter bits for 512 master clocks per frame: 32 slots x 8 bits x 2
    localparam logic [8:0] FRAME_LAST = 9'h1ff;
    // ----------------------------------------
    // timebase presets
    // ----------------------------------------
    localparam logic [8:0] IN_PRESET = 9'h000;
    localparam logic [8:0] TB_GAP = 9'h020; // two slots of latency
    localparam logic [3:0] SLOT_START = 4'h0;
    localparam logic [8:0] EXTRACT_CNT = 9'h011; // slot 0 byte just stored
    // ----------------------------------------
    // host side timing, in master clocks
    // ----------------------------------------
    localparam logic [1:0] HOLD_CYCLES = 2'h3;
    localparam logic [1:0] DR_PULSE_CYCLES = 2'h2;
    // ----------------------------------------
    // store values and opcodes
    // ----------------------------------------
    localparam logic [8:0] CONN_EMPTY = 9'h1ff;
    localparam logic [1:0] NO_MSG_LABEL = 2'h1;
    localparam logic [4:0] OP_CONNECT = 5'h01;
    localparam logic [4:0] OP_DISCONNECT = 5'h02;
    localparam logic [4:0] OP_LOAD_BYTE = 5'h03;
    localparam logic [4:0] OP_SAMPLE = 5'h04;
    localparam logic [4:0] OP_CTRL_WORD = 5'h05;
    localparam logic [4:0] OP_EXTRACT = 5'h06;
endpackage
`default_nettype wire

/* tssm_strobe_edge.sv */
// rising-edge detector for an active-low host strobe
`timescale 1ns/1ps
`default_nettype none
module tssm_strobe_edge (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_strobe_n,
    output logic o_rise
);
    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    logic prev_r; // strobe level one clock ago

    // idle high so reset release makes no false edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= i_strobe_n;
        end
    end

    // combinational so bus inputs are taken in the edge cycle
    assign o_rise = i_strobe_n & ~prev_r & ~i_reset;

    rise_once_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_rise |=> !o_rise)
        else $error("strobe edge longer than one cycle");
endmodule
`default_nettype wire

/* tssm_switch.sv */
// time-slot interchange switch matrix core
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - store each input slot byte per bus
// - entry: speech address or literal, bit8 selects
// - output base leads input by 32
// - two readback registers, memory and opcode
// - read eight bits, write low five
// - bus floats, no transfers in reset
// - select: data/opcode on write, register on read
// - mismatch turns connects off, cancels others except control word
// - drive bus only on match
// - both chip selects low for access
// - write edge captures byte, select, match
// - read edge captures select and match
// - data ready low until valid opcode
// - control word pulses ready for busy entry
// - extraction loads message count, pulses ready
// - reset clears state, store all ones
// - initialisation lasts a frame, repeats
// - bus floats, then serial outputs float
// - bit clock is master clock halved
// - sync presets both timebases
// - serial input sign bit becomes MSB
// - hold registers three cycles after opcode
module tssm_switch (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_sync_n,
    input wire logic [7:0] i_serial_in_buses,
    output logic [7:0] o_serial_out_buses,
    output logic [7:0] o_serial_out_buses_oe,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    input wire logic i_cmd_data,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    input wire logic i_chip_select_first_n,
    input wire logic i_chip_select_second_n,
    input wire logic i_match_a_first,
    input wire logic i_match_b_first,
    input wire logic i_match_a_second,
    input wire logic i_match_b_second,
    output logic o_data_ready_n
);
    // ----------------------------------------
    // timebases and strobes
    // ----------------------------------------
    logic [8:0] in_cnt; // input slot/bit position
    logic [8:0] out_cnt; // output slot/bit position
    logic bit_en; // one pulse per serial bit
    logic wr_rise; // write strobe released
    logic rd_rise; // read strobe released

    tssm_timebase u_timebase (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_sync_n(i_sync_n),
        .o_in_cnt(in_cnt),
        .o_out_cnt(out_cnt),
        .o_bit_en(bit_en)
    );

    tssm_strobe_edge u_wr_edge (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_strobe_n(i_wr_n),
        .o_rise(wr_rise)
    );

    tssm_strobe_edge u_rd_edge (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_strobe_n(i_rd_n),
        .o_rise(rd_rise)
    );

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    // one entry per bus and slot
    logic [7:0] speech_store_r [0:tssm_pkg::ENTRIES-1]; // input samples
    logic [8:0] connection_store_r [0:tssm_pkg::ENTRIES-1]; // routing map
    logic [7:0] in_shift_r [0:tssm_pkg::BUSES-1]; // serial to parallel
    logic [7:0] out_shift_r [0:tssm_pkg::BUSES-1]; // parallel to serial
    logic [4:0] stack_r [0:3]; // data bytes, entry 0 newest
    logic [4:0] instr_r; // last opcode
    logic op_match_r; // match latched with opcode
    logic pending_r; // valid opcode awaiting execution
    logic [1:0] hold_cnt_r; // register freeze countdown
    logic invalid_r; // bad opcode seen
    logic [1:0] dr_pulse_r; // ready pulse countdown
    logic [7:0] first_readback_reg; // memory data
    logic [7:0] second_readback_reg; // opcode copy and status
    logic [7:0] extract_mask_r; // buses to extract from slot 0
    logic extract_on_r; // extraction armed
    logic init_r; // initialisation frame running
    logic last_rd_sel_r; // select of previous read
    logic rd_match_r; // match latched on read edge
    logic cs_ok; // both chip selects active
    logic match_now; // match pins agree
    logic exec_go; // execute this cycle
    logic [7:0] conn_idx; // output bus and channel
    logic [8:0] conn_word; // entry at conn_idx
    logic [4:0] prev_slot; // slot just completed
    logic [3:0] msg_count; // slot 0 messages
    logic ctrl_busy; // control word entry in use
    logic op_valid; // opcode on bus is known

    assign cs_ok = !i_chip_select_first_n && !i_chip_select_second_n;
    // match is equality of both pairs
    assign match_now = (i_match_a_first == i_match_b_first)
        && (i_match_a_second == i_match_b_second);
    assign exec_go = pending_r && (hold_cnt_r == 2'h0);
    assign conn_idx = {stack_r[1][2:0], stack_r[0][4:0]};
    assign conn_word = connection_store_r[conn_idx];
    assign prev_slot = in_cnt[8:4] - 5'h01;
    assign ctrl_busy = conn_word != tssm_pkg::CONN_EMPTY;
    assign op_valid = (i_data[4:0] >= tssm_pkg::OP_CONNECT)
        && (i_data[4:0] <= tssm_pkg::OP_EXTRACT);

    // count masked buses with a slot 0 byte not labelled as empty
    always_comb begin
        msg_count = 4'h0;
        for (int b = 0; b < tssm_pkg::BUSES; b++) begin
            if (extract_mask_r[b] && (speech_store_r[8'(b * tssm_pkg::SLOTS)][7:6]
                != tssm_pkg::NO_MSG_LABEL)) begin
                msg_count = msg_count + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // serial input and speech store
    // ----------------------------------------
    // shift each bus in; first bit ends up as MSB
    // sign bit first
    always_ff @(posedge i_clk) begin
        for (int b = 0; b < tssm_pkg::BUSES; b++) begin
            // cleared so the first stored slot is never unknown
            if (i_reset) begin
                in_shift_r[b] <= 8'h00;
            end else if (bit_en) begin
                in_shift_r[b] <= {in_shift_r[b][6:0], i_serial_in_buses[b]};
            end
        end
    end

    // completed bytes land at {bus, slot} on each slot boundary
    // store at slot start
    always_ff @(posedge i_clk) begin
        if (in_cnt[3:0] == tssm_pkg::SLOT_START) begin
            for (int b = 0; b < tssm_pkg::BUSES; b++) begin
                speech_store_r[{3'(b), prev_slot}] <= in_shift_r[b];
            end
        end
    end

    // ----------------------------------------
    // connection store
    // ----------------------------------------
    // reset fills with ones, which is the disconnected code
    // fill with ones
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int e = 0; e < tssm_pkg::ENTRIES; e++) begin
                connection_store_r[e] <= tssm_pkg::CONN_EMPTY;
            end
        end else if (exec_go) begin
            // unmatched connect or load becomes disconnect
            if ((instr_r == tssm_pkg::OP_CONNECT
                || instr_r == tssm_pkg::OP_LOAD_BYTE) && !op_match_r) begin
                connection_store_r[conn_idx] <= tssm_pkg::CONN_EMPTY;
            end else if (instr_r == tssm_pkg::OP_CONNECT) begin
                connection_store_r[conn_idx] <= {1'b0, stack_r[3][2:0], stack_r[2]};
            end else if (instr_r == tssm_pkg::OP_LOAD_BYTE) begin
                // literal is high nibble from byte 1, low from byte 2
                connection_store_r[conn_idx] <= {1'b1, stack_r[3][3:0], stack_r[2][3:0]};
            end else if (instr_r == tssm_pkg::OP_DISCONNECT && op_match_r) begin
                connection_store_r[conn_idx] <= tssm_pkg::CONN_EMPTY;
            end
        end
    end

    // ----------------------------------------
    // serial output
    // ----------------------------------------
    // each slot loads speech or literal data, then shifts MSB out
    // source select per entry
    always_ff @(posedge i_clk) begin
        for (int b = 0; b < tssm_pkg::BUSES; b++) begin
            if (out_cnt[3:0] == tssm_pkg::SLOT_START) begin
                if (connection_store_r[{3'(b), out_cnt[8:4]}][8]) begin
                    out_shift_r[b] <= connection_store_r[{3'(b), out_cnt[8:4]}][7:0];
                end else begin
                    out_shift_r[b] <= speech_store_r[
                        connection_store_r[{3'(b), out_cnt[8:4]}][7:0]];
                end
            end else if (bit_en) begin
                out_shift_r[b] <= {out_shift_r[b][6:0], 1'b1};
            end
        end
    end

    // open drain: enable only to pull low, never during init
    // outputs float in init
    always_ff @(posedge i_clk) begin
        for (int b = 0; b < tssm_pkg::BUSES; b++) begin
            if (i_reset || init_r) begin
                o_serial_out_buses[b] <= 1'b1;
                o_serial_out_buses_oe[b] <= 1'b0;
            end else begin
                o_serial_out_buses[b] <= out_shift_r[b][7];
                o_serial_out_buses_oe[b] <= !out_shift_r[b][7];
            end
        end
    end

    // ----------------------------------------
    // initialisation frame
    // ----------------------------------------
    // runs to frame end; reset still held in slot 0 restarts it
    // one frame per reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            init_r <= 1'b1;
        end else if (in_cnt == tssm_pkg::FRAME_LAST) begin
            init_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // host writes and instruction flow
    // ----------------------------------------
    // data bytes go on the stack, opcodes arm execution
    // capture on write edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int s = 0; s < 4; s++) begin
                stack_r[s] <= 5'h00;
            end
            instr_r <= 5'h00;
            op_match_r <= 1'b0;
            pending_r <= 1'b0;
            invalid_r <= 1'b0;
            hold_cnt_r <= 2'h0;
            last_rd_sel_r <= 1'b0;
            rd_match_r <= 1'b0;
        end else begin
            if (hold_cnt_r != 2'h0) begin
                hold_cnt_r <= hold_cnt_r - 2'h1;
            end
            if (exec_go) begin
                pending_r <= 1'b0;
            end
            if (wr_rise && cs_ok && i_rd_n && !i_cmd_data) begin
                stack_r[3] <= stack_r[2];
                stack_r[2] <= stack_r[1];
                stack_r[1] <= stack_r[0];
                stack_r[0] <= i_data[4:0];
            end else if (wr_rise && cs_ok && i_rd_n) begin
                instr_r <= i_data[4:0];
                op_match_r <= match_now;
                invalid_r <= !op_valid;
                pending_r <= op_valid;
                hold_cnt_r <= tssm_pkg::HOLD_CYCLES;
            end else if (rd_rise && cs_ok) begin
                last_rd_sel_r <= i_cmd_data;
                rd_match_r <= match_now;
                if (i_cmd_data && !last_rd_sel_r) begin
                    hold_cnt_r <= tssm_pkg::HOLD_CYCLES;
                end
            end
        end
    end

    // ----------------------------------------
    // readback registers and extraction
    // ----------------------------------------
    // last step of an instruction updates the opcode readback, and the memory one for a matched sample or any control word
    // memory data and opcode copy
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            first_readback_reg <= 8'h00;
            second_readback_reg <= 8'h00;
            extract_mask_r <= 8'h00;
            extract_on_r <= 1'b0;
        end else if (exec_go) begin
            second_readback_reg <= {stack_r[1][2:0], instr_r};
            if (instr_r == tssm_pkg::OP_CTRL_WORD) begin
                // control word transfer ignores the match
                first_readback_reg <= conn_word[7:0];
                second_readback_reg <= {stack_r[1][2:0], conn_word[8], instr_r[3:0]};
            end else if (instr_r == tssm_pkg::OP_SAMPLE && op_match_r) begin
                first_readback_reg <= conn_word[8] ? conn_word[7:0]
                    : speech_store_r[conn_word[7:0]];
            end else if (instr_r == tssm_pkg::OP_EXTRACT && op_match_r) begin
                extract_mask_r <= {stack_r[1][3:0], stack_r[0][3:0]};
                extract_on_r <= 1'b1;
            end
        end else if (extract_on_r && in_cnt == tssm_pkg::EXTRACT_CNT
            && msg_count != 4'h0) begin
            second_readback_reg <= {4'h0, msg_count};
        end
    end

    // ----------------------------------------
    // data ready
    // ----------------------------------------
    // short pulse for control word hits and extraction
    // two cycle pulse
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dr_pulse_r <= 2'h0;
        end else if (exec_go && instr_r == tssm_pkg::OP_CTRL_WORD && ctrl_busy) begin
            dr_pulse_r <= tssm_pkg::DR_PULSE_CYCLES;
        end else if (!exec_go && extract_on_r && in_cnt == tssm_pkg::EXTRACT_CNT
            && msg_count != 4'h0) begin
            dr_pulse_r <= tssm_pkg::DR_PULSE_CYCLES;
        end else if (dr_pulse_r != 2'h0) begin
            dr_pulse_r <= dr_pulse_r - 2'h1;
        end
    end

    // the error level outlasts any pulse
    // idle high
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_data_ready_n <= 1'b1;
        end else begin
            o_data_ready_n <= !(invalid_r || dr_pulse_r != 2'h0);
        end
    end

    // ----------------------------------------
    // host read bus
    // ----------------------------------------
    // both strobes low is a fault: float to protect the bus
    // drive only on match
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_data_oe <= 1'b0;
            o_data <= 8'h00;
        end else begin
            o_data_oe <= cs_ok && !i_rd_n && i_wr_n && match_now;
            o_data <= i_cmd_data ? second_readback_reg : first_readback_reg;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    bus_float_reset_a: assert property (@(posedge i_clk)
        i_reset |=> !o_data_oe)
        else $error("bus driven in reset");
    read_match_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !match_now |=> !o_data_oe)
        else $error("bus driven on mismatch");
    store_fill_a: assert property (@(posedge i_clk)
        i_reset |=> connection_store_r[8'hff] == tssm_pkg::CONN_EMPTY)
        else $error("store not filled with ones");
    opcode_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_rise && cs_ok && i_rd_n && i_cmd_data) |=> !exec_go [*3])
        else $error("executed inside hold window");
    pcm_float_a: assert property (@(posedge i_clk) disable iff (i_reset)
        init_r |=> o_serial_out_buses_oe == 8'h00)
        else $error("serial outputs driven in init");
    invalid_dr_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_rise && cs_ok && i_rd_n && i_cmd_data && !op_valid) |=> ##1 !o_data_ready_n)
        else $error("ready not low on bad opcode");
    ctrl_pulse_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (exec_go && instr_r == tssm_pkg::OP_CTRL_WORD && ctrl_busy && !invalid_r)
        |=> ##1 !o_data_ready_n [*2] ##1 o_data_ready_n)
        else $error("control word pulse wrong");
    speech_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (in_cnt[3:0] == tssm_pkg::SLOT_START)
        |=> speech_store_r[{3'h0, $past(prev_slot)}] == $past(in_shift_r[0]))
        else $error("slot byte not stored");
    mismatch_cancel_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (exec_go && !op_match_r && (instr_r == tssm_pkg::OP_CONNECT
        || instr_r == tssm_pkg::OP_LOAD_BYTE))
        |=> connection_store_r[$past(conn_idx)] == tssm_pkg::CONN_EMPTY)
        else $error("unmatched connect not disconnected");
endmodule
`default_nettype wire

/* tssm_timebase.sv */
// input and output timebases with bit-rate enable
`timescale 1ns/1ps
`default_nettype none
module tssm_timebase (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_sync_n,
    output logic [8:0] o_in_cnt,
    output logic [8:0] o_out_cnt,
    output logic o_bit_en
);
    // ----------------------------------------
    // counters
    // ----------------------------------------
    logic [8:0] in_cnt_r; // delayed base, serves inputs
    logic [8:0] out_cnt_r; // advanced base, serves outputs

    // both bases run together; sync forces a known count
    // sync presets bases
    always_ff @(posedge i_clk) begin
        if (i_reset || !i_sync_n) begin
            in_cnt_r <= tssm_pkg::IN_PRESET;
            out_cnt_r <= tssm_pkg::IN_PRESET + tssm_pkg::TB_GAP;
        end else begin
            in_cnt_r <= in_cnt_r + 9'h001;
            out_cnt_r <= out_cnt_r + 9'h001;
        end
    end

    assign o_in_cnt = in_cnt_r;
    assign o_out_cnt = out_cnt_r;
    assign o_bit_en = in_cnt_r[0];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    base_gap_a: assert property (@(posedge i_clk) disable iff (i_reset)
        (out_cnt_r - in_cnt_r) == tssm_pkg::TB_GAP)
        else $error("timebases not 32 apart");
    sync_preset_a: assert property (@(posedge i_clk)
        !i_sync_n |=> in_cnt_r == tssm_pkg::IN_PRESET)
        else $error("sync did not preset input base");
    bit_rate_a: assert property (@(posedge i_clk) disable iff (i_reset || !i_sync_n)
        o_bit_en |=> !o_bit_en ##1 o_bit_en)
        else $error("bit enable not half rate");
endmodule
`default_nettype wire
